//--- rtl/sfp_flash_dev.sv
// Summary of operation
// - 88h, 256 mode: 6 dc, page, 8 dc
// - 88h, 264 mode: 5 dc, page, 9 dc
// - 88h copies buffer to page while busy
// - 82h, 256 mode: 6 dc, page, byte pointer
// - 82h, 264 mode: 5 dc, page, byte pointer
// - 82h data fills buffer, pointer wraps
// - 82h erases page then programs buffer, busy
// - 82h erase/program failure sets error flag
// - 02h, 264 mode: 1..264 bytes, wraps
// - 02h, 256 mode: 1..256 bytes, wraps
// - 256 mode address is 18-bit linear
// - 02h programs only received bytes
// - partial byte at deselect aborts 02h
// - 02h time scales per byte, busy held
// - 81h, 264 mode: 5 dc, page, 9 dc
// - 81h, 256 mode: 6 dc, page, 8 dc
// - 81h sets page to ones, busy held
// - erase failure sets error flag
`include "sfp_params.svh"
module sfp_flash_dev
    import sfp_pkg::*;
#(
    parameter int BP_CYC = `SFP_T_BP_NS / `SFP_CLK_NS,   // per_byte_program_time
    parameter int EB_CYC = `SFP_T_EB_NS / `SFP_CLK_NS    // per-byte erase step
)(
    input  wire logic CLK_I,        // system clock
    input  wire logic ARST_N_I,     // async reset, low
    sfp_link_if.dev   LINK,         // serial link
    input  wire logic PAGE_264_I,   // 264-byte page mode
    input  wire logic FAULT_I,      // makes erase verify fail
    output logic      BUSY_O,       // operation running
    output logic      ERR_O         // erase_program_error_flag
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and filter
    logic [2:0]        sync1_q, sync2_q, sync3_q;   // {cs_n, sck, si} chain
    logic [2:0]        filt_q, filt_d;              // agreed levels
    logic              cs_f, sck_f, si_f;           // filtered pins
    logic              cs_prev_q, sck_prev_q;       // for edge finding
    logic              sck_rise, cs_rise, cs_fall;  // pin events

    // a change counts once stages two and three agree
    always_comb begin
        filt_d = ((sync2_q ~^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);
    end

    // registers of the synchroniser chain
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync1_q    <= '1;
            sync2_q    <= '1;
            sync3_q    <= '1;
            filt_q     <= '1;
            cs_prev_q  <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= {LINK.cs_n, LINK.sck, LINK.si};
            sync2_q    <= sync1_q;
            sync3_q    <= sync2_q;
            filt_q     <= filt_d;
            cs_prev_q  <= filt_q[2];
            sck_prev_q <= filt_q[1];
        end
    end

    assign cs_f     = filt_q[2];
    assign sck_f    = filt_q[1];
    assign si_f     = filt_q[0];
    assign sck_rise = sck_f & ~sck_prev_q & ~cs_f;
    assign cs_rise  = cs_f & ~cs_prev_q;
    assign cs_fall  = ~cs_f & cs_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    sfp_byte_type      buf_mem  [0:`SFP_PAGE_264-1];   // sram data buffer
    sfp_byte_type      main_mem [0:`SFP_MEM_WORDS-1];  // main array
    logic              buf_we, mem_we;                 // write strobes
    logic [8:0]        buf_wa;                         // buffer write address
    sfp_byte_type      buf_wd, mem_wd;                 // write data
    logic [18:0]       mem_idx;                        // array index of idx_q
    sfp_byte_type      mem_rd, buf_rd;                 // read data

    ////////////////////////////////////////////////////////////////////////////
    // receiver and sequencer state
    sfp_dev_state_type st_q, st_d;                  // sequencer state
    sfp_byte_type      sh_q, sh_d;                  // input shifter
    logic [2:0]        bit_q, bit_d;                // bit in byte
    logic [2:0]        hdr_q, hdr_d;                // bytes of header seen
    sfp_byte_type      op_q, op_d;                  // opcode
    logic [23:0]       addr_q, addr_d;              // address bytes
    logic [9:0]        pg_q, pg_d;                  // page_number_bits
    logic [8:0]        ptr_q, ptr_d;                // buffer_byte_pointer
    logic [8:0]        idx_q, idx_d;                // byte walked by sequencer
    logic [15:0]       wait_q, wait_d;              // step timer
    logic [263:0]      mark_q, mark_d;              // bytes received by 82h or 02h
    logic              m264_q, m264_d;              // page mode of the frame
    logic              busy_q, busy_d;              // busy flag
    logic              err_q, err_d;                // error flag
    logic [8:0]        last;                        // last byte of page
    sfp_byte_type      byte_v;                      // byte just completed
    logic [23:0]       naddr;                       // address with byte_v
    logic [17:0]       lin;                         // linear_byte_address
    sfp_byte_type      prog_v;                      // value after programming

    assign last    = m264_q ? `SFP_PAGE_264 - 9'h1 : `SFP_PAGE_256 - 9'h1;
    assign mem_idx = 19'(pg_q) * 19'(`SFP_PAGE_264) + 19'(idx_q);
    assign mem_rd  = main_mem[mem_idx];
    assign buf_rd  = buf_mem[idx_q];

    // next-state logic of frame decode and self-timed walk
    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        bit_d  = bit_q;
        hdr_d  = hdr_q;
        op_d   = op_q;
        addr_d = addr_q;
        pg_d   = pg_q;
        ptr_d  = ptr_q;
        idx_d  = idx_q;
        wait_d = wait_q;
        mark_d = mark_q;
        m264_d = m264_q;
        busy_d = busy_q;
        err_d  = err_q;
        buf_we = 1'b0;
        buf_wa = ptr_q;
        buf_wd = sh_q;
        mem_we = 1'b0;
        mem_wd = `SFP_ERASED;
        byte_v = {sh_q[6:0], si_f};
        naddr  = {addr_q[15:0], byte_v};
        lin    = naddr[`SFP_LIN_MSB:0];
        prog_v = mem_rd & buf_rd;
        case (st_q)
            DS_RECV: begin
                if (cs_fall) begin                      // new frame
                    bit_d  = '0;
                    hdr_d  = '0;
                    op_d   = `SFP_OP_NONE;
                    mark_d = '0;
                    m264_d = PAGE_264_I;
                end else if (sck_rise) begin
                    sh_d  = byte_v;
                    bit_d = bit_q + 3'h1;
                    if (bit_q == `SFP_LAST_BIT) begin   // byte complete
                        if (hdr_q == 3'h0) begin
                            op_d = byte_v;
                        end else if (hdr_q != `SFP_HDR_BYTES) begin
                            addr_d = naddr;
                        end
                        if (hdr_q == `SFP_HDR_BYTES - 3'h1) begin
                            pg_d  = m264_q ? naddr[`SFP_PG264_MSB:`SFP_PG264_LSB]
                                           : lin[`SFP_LIN_MSB:`SFP_PG256_LSB];
                            ptr_d = m264_q ? naddr[`SFP_BP264_MSB:0]
                                           : {1'b0, naddr[`SFP_BP256_MSB:0]};
                        end
                        if (hdr_q != `SFP_HDR_BYTES) begin
                            hdr_d = hdr_q + 3'h1;
                        end else if (op_q == `SFP_OP_ERASE_PROG
                                     || op_q == `SFP_OP_BYTE_PROG) begin
                            buf_we        = 1'b1;
                            buf_wd        = byte_v;
                            mark_d[ptr_q] = 1'b1;
                            ptr_d = (ptr_q == last) ? 9'h0 : ptr_q + 9'h1;
                        end
                    end
                end else if (cs_rise && bit_q == 3'h0 && hdr_q == `SFP_HDR_BYTES) begin
                    // partial byte or short header starts nothing
                    idx_d  = '0;
                    wait_d = '0;
                    op_d   = `SFP_OP_NONE;
                    case (op_q)
                        `SFP_OP_BUF_PROG, `SFP_OP_BYTE_PROG: begin
                            st_d   = DS_PROG;
                            busy_d = 1'b1;
                            err_d  = 1'b0;
                        end
                        `SFP_OP_ERASE_PROG, `SFP_OP_PAGE_ERASE: begin
                            st_d   = DS_ERASE;
                            busy_d = 1'b1;
                            err_d  = 1'b0;
                        end
                        default: begin                      // not covered here
                            st_d = DS_RECV;
                        end
                    endcase
                    op_d = (st_d == DS_RECV) ? `SFP_OP_NONE : op_q;
                end
            end
            DS_ERASE: begin
                if (wait_q != 16'h0) begin
                    wait_d = wait_q - 16'h1;
                end else begin
                    mem_we = 1'b1;                      // byte to ones
                    err_d  = err_q | FAULT_I;
                    wait_d = 16'(EB_CYC - 1);
                    idx_d  = idx_q + 9'h1;
                    if (idx_q == last) begin
                        idx_d  = '0;
                        if (op_q == `SFP_OP_ERASE_PROG) begin
                            st_d = DS_PROG;
                        end else begin
                            st_d   = DS_RECV;
                            busy_d = 1'b0;
                            op_d   = `SFP_OP_NONE;
                        end
                    end
                end
            end
            DS_PROG: begin
                if (wait_q != 16'h0) begin
                    wait_d = wait_q - 16'h1;
                end else begin
                    if (op_q != `SFP_OP_BYTE_PROG || mark_q[idx_q]) begin
                        mem_we = 1'b1;                  // bits only go to zero
                        mem_wd = prog_v;
                        err_d  = err_q | (prog_v != buf_rd);
                        wait_d = 16'(BP_CYC - 1);
                    end
                    idx_d = idx_q + 9'h1;
                    if (idx_q == last) begin
                        st_d   = DS_RECV;
                        busy_d = 1'b0;
                        op_d   = `SFP_OP_NONE;
                    end
                end
            end
            default: begin
                st_d   = DS_RECV;
                busy_d = 1'b0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q   <= DS_RECV;
            sh_q   <= '0;
            bit_q  <= '0;
            hdr_q  <= '0;
            op_q   <= `SFP_OP_NONE;
            addr_q <= '0;
            pg_q   <= '0;
            ptr_q  <= '0;
            idx_q  <= '0;
            wait_q <= '0;
            mark_q <= '0;
            m264_q <= 1'b0;
            busy_q <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            bit_q  <= bit_d;
            hdr_q  <= hdr_d;
            op_q   <= op_d;
            addr_q <= addr_d;
            pg_q   <= pg_d;
            ptr_q  <= ptr_d;
            idx_q  <= idx_d;
            wait_q <= wait_d;
            mark_q <= mark_d;
            m264_q <= m264_d;
            busy_q <= busy_d;
            err_q  <= err_d;
        end
    end

    // memory writes, arrays carry no reset
    always_ff @(posedge CLK_I) begin
        if (buf_we) begin
            buf_mem[buf_wa] <= buf_wd;
        end
        if (mem_we) begin
            main_mem[mem_idx] <= mem_wd;
        end
    end

    assign BUSY_O    = busy_q;
    assign ERR_O     = err_q;
    assign LINK.busy = busy_q;
    assign LINK.err  = err_q;
endmodule // sfp_flash_dev

//--- common/sfp_params.svh
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
// opcodes of the covered program and erase commands
`define SFP_OP_BUF_PROG   8'h88
`define SFP_OP_ERASE_PROG 8'h82
`define SFP_OP_BYTE_PROG  8'h02
`define SFP_OP_PAGE_ERASE 8'h81
`define SFP_OP_NONE       8'h00
// array geometry
`define SFP_PAGE_264      9'h108
`define SFP_PAGE_256      9'h100
`define SFP_MEM_WORDS     270336
`define SFP_HDR_BYTES     3'h4
`define SFP_LAST_BIT      3'h7
`define SFP_HDR_BITS      6'h1F
`define SFP_ERASED        8'hFF
// address fields
`define SFP_PG264_MSB     18
`define SFP_PG264_LSB     9
`define SFP_LIN_MSB       17
`define SFP_PG256_LSB     8
`define SFP_BP264_MSB     8
`define SFP_BP256_MSB     7
// timing
`define SFP_CLK_NS        50
`define SFP_T_BP_NS       6000
`define SFP_T_EB_NS       2000
`define SFP_SCK_HALF      4'h4
`define SFP_GAP_CYC       5'h10
`endif

//--- common/sfp_pkg.sv
package sfp_pkg;
    typedef logic [7:0] sfp_byte_type;                       // one link byte
    typedef enum {DS_RECV, DS_ERASE, DS_PROG} sfp_dev_state_type;
    typedef enum {HS_IDLE, HS_SHIFT, HS_FEED, HS_GAP, HS_WAIT} sfp_host_state_type;
endpackage

//--- common/sfp_link_if.sv
interface sfp_link_if;
    logic cs_n;   // chip select, low for a frame
    logic sck;    // serial clock made by the host
    logic si;     // serial data into the device
    logic busy;   // device self-timed operation running
    logic err;    // device error flag
    modport dev  (input cs_n, sck, si, output busy, err);
    modport host (output cs_n, sck, si, input busy, err);
endinterface

//--- rtl/sfp_spi_host.sv
`include "sfp_params.svh"
module sfp_spi_host
    import sfp_pkg::*;
(
    input  wire logic  CLK_I,         // system clock
    input  wire logic  ARST_N_I,      // async reset, low
    sfp_link_if.host   LINK,          // serial link
    input  wire logic  CMD_VALID_I,   // command offered
    input  wire logic  [7:0] CMD_OP_I,    // opcode
    input  wire logic  [23:0] CMD_ADDR_I, // three address bytes
    input  wire logic  [8:0] CMD_LEN_I,   // data bytes to send
    output logic       CMD_READY_O,   // command taken when high
    input  wire logic  DATA_VALID_I,  // data byte offered
    input  wire logic  [7:0] DATA_I,  // data byte
    output logic       DATA_READY_O,  // buffer has room
    output logic       DONE_O,        // command finished pulse
    output logic       BUSY_O,        // device busy seen
    output logic       ERR_O          // device error seen
);
    ////////////////////////////////////////////////////////////////////////////
    // status synchronisers
    logic [1:0]         sync1_q, sync2_q, sync3_q; // {busy, err} chain
    logic [1:0]         filt_q, filt_d;            // agreed levels

    // a change counts once stages two and three agree
    always_comb begin
        filt_d = ((sync2_q ~^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);
    end

    // synchroniser registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q  <= '0;
        end else begin
            sync1_q <= {LINK.busy, LINK.err};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry data buffer and shifter
    sfp_byte_type       fm_q [0:1];                 // entries
    sfp_byte_type       fm_d [0:1];
    logic               wp_q, wp_d, rp_q, rp_d;     // pointers
    logic [1:0]         cnt_q, cnt_d;               // fill level
    logic               drdy_q, drdy_d;             // room for a byte
    logic               push, pop;                  // buffer handshakes
    sfp_host_state_type st_q, st_d;                 // sequencer state
    logic [31:0]        sh_q, sh_d;                 // outgoing bits
    logic [5:0]         bits_q, bits_d;             // bits left in unit
    logic [8:0]         len_q, len_d;               // data bytes left
    logic [3:0]         div_q, div_d;               // sck divider
    logic [4:0]         gap_q, gap_d;               // deselect time
    logic               cs_n_q, cs_n_d, sck_q, sck_d, si_q, si_d;
    logic               crdy_q, crdy_d, done_q, done_d, busy_q, err_q, err_d;
    logic               tick;                       // half-period enable

    assign tick = (div_q == 4'h0);
    assign push = DATA_VALID_I & drdy_q;

    // next-state logic
    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        bits_d = bits_q;
        len_d  = len_q;
        div_d  = tick ? `SFP_SCK_HALF - 4'h1 : div_q - 4'h1;
        gap_d  = gap_q;
        cs_n_d = cs_n_q;
        sck_d  = sck_q;
        si_d   = si_q;
        crdy_d = 1'b0;
        done_d = 1'b0;
        err_d  = err_q;
        pop    = 1'b0;
        case (st_q)
            HS_IDLE: begin
                crdy_d = 1'b1;
                if (CMD_VALID_I && crdy_q) begin
                    crdy_d = 1'b0;
                    sh_d   = {CMD_OP_I, CMD_ADDR_I};    // msb first
                    si_d   = CMD_OP_I[7];
                    bits_d = `SFP_HDR_BITS;
                    len_d  = CMD_LEN_I;
                    cs_n_d = 1'b0;
                    div_d  = `SFP_SCK_HALF - 4'h1;
                    st_d   = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                if (tick) begin
                    sck_d = ~sck_q;
                    if (sck_q) begin                    // falling edge
                        if (bits_q != 6'h0) begin
                            sh_d   = {sh_q[30:0], 1'b0};
                            si_d   = sh_q[30];
                            bits_d = bits_q - 6'h1;
                        end else if (len_q != 9'h0) begin
                            st_d = HS_FEED;
                        end else begin
                            cs_n_d = 1'b1;              // whole bytes only
                            gap_d  = `SFP_GAP_CYC;
                            st_d   = HS_GAP;
                        end
                    end
                end
            end
            HS_FEED: begin                              // stalls on empty buffer
                if (cnt_q != 2'h0) begin
                    pop    = 1'b1;
                    sh_d   = {fm_q[rp_q], 24'h0};
                    si_d   = fm_q[rp_q][7];
                    bits_d = {3'h0, `SFP_LAST_BIT};
                    len_d  = len_q - 9'h1;
                    div_d  = `SFP_SCK_HALF - 4'h1;
                    st_d   = HS_SHIFT;
                end
            end
            HS_GAP: begin                               // let busy reach us
                gap_d = gap_q - 5'h1;
                if (gap_q == 5'h0) begin
                    st_d = HS_WAIT;
                end
            end
            HS_WAIT: begin                              // pre-erase is caller's
                if (!filt_q[1]) begin
                    done_d = 1'b1;
                    err_d  = filt_q[0];
                    st_d   = HS_IDLE;
                end
            end
            default: begin
                st_d   = HS_IDLE;
                cs_n_d = 1'b1;
            end
        endcase
        // buffer bookkeeping
        fm_d[0] = fm_q[0];
        fm_d[1] = fm_q[1];
        if (push) begin
            fm_d[wp_q] = DATA_I;
        end
        wp_d   = wp_q ^ push;
        rp_d   = rp_q ^ pop;
        cnt_d  = cnt_q + {1'b0, push} - {1'b0, pop};
        drdy_d = (cnt_d != 2'h2);
    end

    // registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q   <= HS_IDLE;
            sh_q   <= '0;
            bits_q <= '0;
            len_q  <= '0;
            div_q  <= '0;
            gap_q  <= '0;
            cs_n_q <= 1'b1;
            sck_q  <= 1'b0;
            si_q   <= 1'b0;
            crdy_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            err_q  <= 1'b0;
            fm_q[0] <= '0;
            fm_q[1] <= '0;
            wp_q   <= 1'b0;
            rp_q   <= 1'b0;
            cnt_q  <= '0;
            drdy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            bits_q <= bits_d;
            len_q  <= len_d;
            div_q  <= div_d;
            gap_q  <= gap_d;
            cs_n_q <= cs_n_d;
            sck_q  <= sck_d;
            si_q   <= si_d;
            crdy_q <= crdy_d;
            done_q <= done_d;
            busy_q <= filt_q[1];
            err_q  <= err_d;
            fm_q[0] <= fm_d[0];
            fm_q[1] <= fm_d[1];
            wp_q   <= wp_d;
            rp_q   <= rp_d;
            cnt_q  <= cnt_d;
            drdy_q <= drdy_d;
        end
    end

    assign LINK.cs_n    = cs_n_q;
    assign LINK.sck     = sck_q;
    assign LINK.si      = si_q;
    assign CMD_READY_O  = crdy_q;
    assign DATA_READY_O = drdy_q;
    assign DONE_O       = done_q;
    assign BUSY_O       = busy_q;
    assign ERR_O        = err_q;
endmodule // sfp_spi_host

//--- verification/sfp_link_sva.sv
module sfp_link_sva #(
    parameter int MAX_BUSY = 1056    // longest self-timed walk in cycles
)(
    input wire logic CLK_I,     // system clock
    input wire logic ARST_N_I,  // async reset, low
    input wire logic cs_n,      // chip select
    input wire logic sck,       // serial clock
    input wire logic si,        // serial data
    input wire logic busy,      // device busy
    input wire logic err        // device error flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        sck_q, sck_d;    // last sck level
    logic [11:0] bits_q, bits_d;  // sck rises in frame
    logic [10:0] bcnt_q, bcnt_d;  // busy run length
    ////////////////////////////////////////////////////////////////
    // helper counters
    always_comb begin
        sck_d  = sck;
        bits_d = cs_n ? 12'h000 : bits_q + {11'h000, sck & ~sck_q};
        bcnt_d = busy ? bcnt_q + 11'h001 : 11'h000;
    end
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sck_q  <= 1'b0;
            bits_q <= 12'h000;
            bcnt_q <= 11'h000;
        end else begin
            sck_q  <= sck_d;
            bits_q <= bits_d;
            bcnt_q <= bcnt_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence s_frame_end; $rose(cs_n); endsequence
    sequence s_op_start;  $rose(busy); endsequence
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("sck high outside a frame");
    a_si_stable_high: assert property (sck && $past(sck) |-> $stable(si))
        else $error("si moved while sck high");
    a_frame_whole_bytes: assert property (s_frame_end |-> bits_q[2:0] == 3'h0)
        else $error("frame ended mid byte");
    a_busy_after_cs: assert property (s_frame_end |-> ##[3:6] s_op_start)
        else $error("busy did not follow deselect");
    a_busy_cause_cs: assert property (s_op_start |-> cs_n && !$past(cs_n, 6))
        else $error("busy rose without a frame");
    a_busy_min_run: assert property (s_op_start |-> busy [*8])
        else $error("busy too short");
    a_busy_max_run: assert property (bcnt_q <= MAX_BUSY)
        else $error("busy too long");
    a_no_frame_busy: assert property (busy |-> cs_n)
        else $error("frame during busy");
    a_err_in_op: assert property ($rose(err) |-> busy || $past(busy))
        else $error("error flag set outside an operation");
endmodule // sfp_link_sva

//--- verification/serial_flash_program_erase_tb.sv
module serial_flash_program_erase_tb import sfp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] op; logic [23:0] addr; logic [8:0] len;
        logic p264; logic fault; sfp_byte_type dat; logic err;
    } sfp_row_type;                                  // stimulus beside expected error
    sfp_row_type rows [11];
    logic        clk, rst_n, p264, fault, cv, cr, dv, dr, done, hb, he, db, de, seen;
    logic [7:0]  op, dat;
    logic [23:0] addr;
    logic [8:0]  len, n_push;
    int          n_errors, tests_run, k;
    sfp_link_if link ();
    sfp_flash_dev #(.BP_CYC(2), .EB_CYC(2)) i_sfp_flash_dev (.CLK_I(clk), .ARST_N_I(rst_n),
        .LINK(link), .PAGE_264_I(p264), .FAULT_I(fault), .BUSY_O(db), .ERR_O(de));
    sfp_spi_host i_sfp_spi_host (.CLK_I(clk), .ARST_N_I(rst_n), .LINK(link),
        .CMD_VALID_I(cv), .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_LEN_I(len),
        .CMD_READY_O(cr), .DATA_VALID_I(dv), .DATA_I(dat), .DATA_READY_O(dr),
        .DONE_O(done), .BUSY_O(hb), .ERR_O(he));
    // busy limit is 264 bytes of erase plus program, two flops of margin
    sfp_link_sva #(.MAX_BUSY(1058)) i_sfp_link_sva (.CLK_I(clk), .ARST_N_I(rst_n),
        .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .busy(link.busy), .err(link.err));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // data feed offers exactly len bytes per command
    always @(negedge clk) dv <= (n_push < len);
    always @(posedge clk) if (dv === 1'b1 && dr === 1'b1) n_push <= n_push + 9'h001;
    always @(posedge clk) if (hb === 1'b1) seen <= 1'b1;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen_v, input logic [7:0] exp);
        tests_run++;
        if (seen_v !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen_v);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_for(input bit is_done, input int lim);
        k = 0;
        do begin @(negedge clk); k++; end
        while ((is_done ? done : cr) !== 1'b1 && k < lim);
        if (k >= lim) begin n_errors++; complete_run(); end
    endtask
    task automatic issue(input sfp_row_type r);
        wait_for(1'b0, 100);
        {op, addr, len, p264, fault, dat} <= {r.op, r.addr, r.len, r.p264, r.fault, r.dat};
        {cv, n_push, seen} <= {1'b1, 9'h000, 1'b0};
        @(negedge clk);
        cv <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, p264, fault, cv, dat, op, addr, len, n_push, seen} = '0;
        {n_errors, tests_run} = '0;
        rows[0]  = '{8'h81, 24'h000100, 9'h0, 1'h0, 1'h0, 8'h00, 1'h0};
        rows[1]  = '{8'h81, 24'h000100, 9'h0, 1'h0, 1'h1, 8'h00, 1'h1};
        rows[2]  = '{8'h81, 24'h000200, 9'h0, 1'h0, 1'h0, 8'h00, 1'h0};
        rows[3]  = '{8'h02, 24'h0002FF, 9'h2, 1'h0, 1'h0, 8'h00, 1'h0};
        rows[4]  = '{8'h02, 24'h000200, 9'h1, 1'h0, 1'h0, 8'hFF, 1'h1};
        rows[5]  = '{8'h02, 24'h000201, 9'h1, 1'h0, 1'h0, 8'h00, 1'h0};
        // full 264 bytes: fills the whole buffer before whole-page programs
        rows[6]  = '{8'h82, 24'h000600, 9'h108, 1'h1, 1'h0, 8'h00, 1'h0};
        rows[7]  = '{8'h82, 24'h000600, 9'h1, 1'h1, 1'h1, 8'h00, 1'h1};
        rows[8]  = '{8'h81, 24'h000800, 9'h0, 1'h1, 1'h0, 8'h00, 1'h0};
        rows[9]  = '{8'h88, 24'h000800, 9'h0, 1'h1, 1'h0, 8'h00, 1'h0};
        rows[10] = '{8'h82, 24'h000500, 9'h1, 1'h0, 1'h0, 8'h00, 1'h0};
        repeat (10) @(negedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            issue(rows[i]);
            wait_for(1'b1, 20000);
            chk("device error", de, rows[i].err);
            chk("device busy", db, 8'h00);
            @(negedge clk);
            chk("host error", he, rows[i].err);
            chk("busy seen", seen, 8'h01);
            $display("test row %0d finished", i);
        end
        // reset in mid operation drops the link to idle
        issue(rows[2]);
        for (k = 0; k < 2000 && hb !== 1'b1; k++) @(negedge clk);
        if (hb !== 1'b1) begin n_errors++; complete_run(); end
        rst_n <= 1'b0;
        @(negedge clk);
        chk("link idle", {link.cs_n, link.sck, link.busy, cr}, 8'h08);
        @(negedge clk);
        rst_n <= 1'b1;
        issue(rows[0]);
        wait_for(1'b1, 20000);
        chk("error after reset", de, 8'h00);
        $display("test reset finished");
        complete_run();
    end
endmodule // serial_flash_program_erase_tb
